/* rtl/lbx_core.sv */
// execution slice: and, add-product, mask-memory, branches, bit tests
// assumes one decoded instruction per accepted strobe, a data memory
// that shows read data while dmem_rd_o stands, and wishbone for regs;
// external_branch_input_i is asynchronous and synchronised here
`timescale 1ns/100ps
`default_nettype none
`include "lbx_params.svh"
// Notes on behaviour
// [RQ1] memory and: and word with low acc, upper acc cleared
// [RQ2] immediate and: shift constant first, zeros elsewhere
// [RQ3] immediate and with shift: result lands in accumulator
// [RQ4] add product: shift product by mode bits, add to accumulator
// [RQ5] mask memory: word and mask-register or constant, written back
// [RQ6] mask memory: flag set when written result zero, else cleared
// [RQ7] jump: go to target, apply aux register and pointer update
// [RQ8] delayed forms run two more words before transfer
// [RQ9] jump via accumulator takes low 16 accumulator bits
// [RQ10] aux loop: test aux nonzero, 9 bits on legacy form
// [RQ11] aux loop: decrement aux by default, else given update
// [RQ12] jump on flag set only when flag is one
// [RQ13] jump on flag clear only when flag is zero
// [RQ14] jump on carry only when carry is one
// [RQ15] conditional jump: all selected conditions must hold
// [RQ16] nonneg jump on acc >= 0, positive jump on acc > 0
// [RQ17] pin jump when external input low, held low by outside
// [RQ18] bit test copies selected memory bit into test flag
// [RQ19] indexed test uses low 4 multiplicand bits, or second one
// [RQ20] failed condition: fall through, aux update still applied
module lbx_core
  import lbx_pkg::*;
#(
  parameter int AUX_COUNT = 8
) (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // decoded instruction
  input wire logic instr_valid_i,
  input wire lbx_instr_s instr_i,
  input wire logic [15:0] next_pc_i,
  output logic busy_o,
  // program flow
  output logic jump_o,
  output logic [15:0] jump_addr_o,
  // data memory
  output logic dmem_rd_o,
  output logic dmem_wr_o,
  output logic [15:0] dmem_wdata_o,
  input wire logic [15:0] dmem_rdata_i,
  // core state inputs
  input wire logic [31:0] product_i,
  input wire logic [15:0] mult_i,
  input wire logic [15:0] second_mult_i,
  input wire logic carry_i,
  input wire logic external_branch_input_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // observed state
  output logic [31:0] acc_o,
  output logic test_flag_o
);
  // width of the aux index
  localparam int AW = $clog2(AUX_COUNT);
  // register offsets (word index)
  localparam logic [3:0] A_ACC = `LBX_REG_ACC;
  localparam logic [3:0] A_MASK = `LBX_REG_MASK;
  localparam logic [3:0] A_STAT = `LBX_REG_STAT;
  localparam logic [3:0] A_AUXP = `LBX_REG_AUXP;
  localparam logic [3:0] A_AUX = `LBX_REG_AUX;

  // architectural state of the slice
  logic [31:0] acc_reg;
  logic [15:0] dynamic_mask_reg;
  logic [15:0] aux_pointer_reg [AUX_COUNT];
  logic [2:0] aux_select_ptr;
  logic [1:0] product_shift_mode;
  logic test_flag;
  logic [15:0] status_word_one;
  // memory sequencer and delayed jump bookkeeping
  lbx_state_e state_reg;
  lbx_instr_s hold_reg;
  logic [1:0] delay_cnt_reg;
  logic [15:0] pend_addr_reg;
  // pin synchroniser, idle high
  logic [1:0] sync_pin;
  logic pin_low;

  // external pin passes two flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_pin <= `LBX_PIN_IDLE;
    end else if (ce_i) begin
      sync_pin <= {sync_pin[0], external_branch_input_i};
    end
  end
  // only the second stage is read; the first may be metastable
  assign pin_low = ~sync_pin[1];

  // product shift per mode bits
  // mode 3 shifts right keeping the sign, modes 1 and 2 shift left, mode 0 passes the product unshifted
  function automatic logic [31:0] prod_shift(input logic [31:0] p, input logic [1:0] m);
    case (m)
      2'h1: prod_shift = p << `LBX_PM_SHL1;
      2'h2: prod_shift = p << `LBX_PM_SHL4;
      2'h3: prod_shift = 32'($signed(p) >>> `LBX_PM_SHR6);
      default: prod_shift = p;
    endcase
  endfunction : prod_shift

  // selected bit, bit code counts from msb
  // code 0 picks bit 15, code 15 picks bit 0
  function automatic logic pick_bit(input logic [15:0] w, input logic [3:0] code);
    pick_bit = w[4'hf - code];
  endfunction : pick_bit

  // decode helpers shared by several processes
  logic [15:0] cur_aux;
  logic aux_nz;
  logic cond_ok;
  logic acc_zero;
  logic [31:0] imm_sh;
  logic [8:0] cm;
  // aux register that the pointer selects
  assign cur_aux = aux_pointer_reg[aux_select_ptr[AW-1:0]];
  assign acc_zero = (acc_reg == 32'h0);
  assign cm = instr_i.cond_mask;
  // [RQ2] constant shifted, zeros around
  assign imm_sh = {16'h0, instr_i.imm} << instr_i.shift;
  // [RQ10] legacy form tests only 9 low bits
  assign aux_nz = instr_i.legacy_aux ? (cur_aux[`LBX_OLD_AUX_W-1:0] != 9'h0)
                                     : (cur_aux != 16'h0);

  // branch condition
  always_comb begin
    case (instr_i.op)
      `LBX_OP_JUMP, `LBX_OP_JUMP_ACC: cond_ok = 1'b1;
      `LBX_OP_LOOP_AUX: cond_ok = aux_nz;
      // [RQ12] flag set
      `LBX_OP_JUMP_FSET: cond_ok = test_flag;
      // [RQ13] flag clear
      `LBX_OP_JUMP_FCLR: cond_ok = ~test_flag;
      // [RQ14] carry set
      `LBX_OP_JUMP_CARRY: cond_ok = carry_i;
      // [RQ16] sign tests
      `LBX_OP_JUMP_NONNEG: cond_ok = ~acc_reg[31];
      `LBX_OP_JUMP_POS: cond_ok = ~acc_reg[31] & ~acc_zero;
      // [RQ17] pin held low
      `LBX_OP_JUMP_PIN_LOW: cond_ok = pin_low;
      // [RQ15] every selected condition
      `LBX_OP_COND_JUMP: cond_ok =
        (~cm[`LBX_CND_ZERO] | acc_zero) & (~cm[`LBX_CND_NONZERO] | ~acc_zero) &
        (~cm[`LBX_CND_NEG] | acc_reg[31]) &
        (~cm[`LBX_CND_POS] | (~acc_reg[31] & ~acc_zero)) &
        (~cm[`LBX_CND_CARRY] | carry_i) & (~cm[`LBX_CND_NOCARRY] | ~carry_i) &
        (~cm[`LBX_CND_FSET] | test_flag) & (~cm[`LBX_CND_FCLR] | ~test_flag) &
        (~cm[`LBX_CND_PIN_LOW] | pin_low);
      default: cond_ok = 1'b0;
    endcase
  end

  // instruction class and acceptance
  logic is_branch;
  logic is_mem;
  logic go;
  assign is_branch = (instr_i.op >= `LBX_OP_JUMP) && (instr_i.op <= `LBX_OP_JUMP_PIN_LOW);
  assign is_mem = (instr_i.op == `LBX_OP_AND_MEM) || (instr_i.op == `LBX_OP_MASK_MEM) ||
                  (instr_i.op == `LBX_OP_BIT_TEST) || (instr_i.op == `LBX_OP_PROBE_IDX);
  // an instruction is taken only while the sequencer is idle
  assign go = ce_i && instr_valid_i && (state_reg == LBX_IDLE);

  // one hit per request: the standing ack blocks a second
  logic wb_hit;
  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // memory access sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= LBX_IDLE;
      hold_reg <= '0;
      dmem_rd_o <= 1'b0;
      dmem_wr_o <= 1'b0;
      dmem_wdata_o <= 16'h0;
    end else if (ce_i) begin
      dmem_rd_o <= 1'b0;
      dmem_wr_o <= 1'b0;
      case (state_reg)
        LBX_IDLE: begin
          if (go && is_mem) begin
            hold_reg <= instr_i;
            dmem_rd_o <= 1'b1;
            state_reg <= LBX_MEM_RD;
          end
        end
        // read data stands now; and and bit tests finish here
        LBX_MEM_RD: begin
          if (hold_reg.op == `LBX_OP_MASK_MEM) begin
            // [RQ5] and with mask or constant, write back
            dmem_wdata_o <= dmem_rdata_i & (hold_reg.use_imm ? hold_reg.imm : dynamic_mask_reg);
            dmem_wr_o <= 1'b1;
            state_reg <= LBX_MEM_WR;
          end else begin
            state_reg <= LBX_IDLE;
          end
        end
        // write pulse is out, back to idle
        LBX_MEM_WR: state_reg <= LBX_IDLE;
        default: state_reg <= LBX_IDLE;
      endcase
    end
  end

  // accumulator
  // a software write wins over an instruction in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_reg <= `LBX_ACC_RST;
    end else if (ce_i) begin
      if (wb_hit && wb_we_i && wb_adr_i == A_ACC && wb_sel_i == 4'hf) begin
        acc_reg <= wb_dat_i;
      end else if (go && instr_i.op == `LBX_OP_AND_IMM) begin
        // [RQ3] shifted constant and accumulator
        acc_reg <= acc_reg & imm_sh;
      end else if (go && instr_i.op == `LBX_OP_ADD_PROD) begin
        // [RQ4] shifted product added
        acc_reg <= acc_reg + prod_shift(product_i, product_shift_mode);
      end else if (state_reg == LBX_MEM_RD && hold_reg.op == `LBX_OP_AND_MEM) begin
        // [RQ1] upper half forced to zero
        acc_reg <= {16'h0, acc_reg[15:0] & dmem_rdata_i};
      end
    end
  end

  // test flag
  // hardware updates win over a software write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      test_flag <= 1'b0;
    end else if (ce_i) begin
      if (state_reg == LBX_MEM_RD && hold_reg.op == `LBX_OP_MASK_MEM) begin
        // [RQ6] flag from written result
        test_flag <= ((dmem_rdata_i & (hold_reg.use_imm ? hold_reg.imm : dynamic_mask_reg))
                      == 16'h0);
      end else if (state_reg == LBX_MEM_RD && hold_reg.op == `LBX_OP_BIT_TEST) begin
        // [RQ18] coded bit to flag
        test_flag <= pick_bit(dmem_rdata_i, hold_reg.bit_code);
      end else if (state_reg == LBX_MEM_RD && hold_reg.op == `LBX_OP_PROBE_IDX) begin
        // [RQ19] index from multiplicand low bits
        test_flag <= pick_bit(dmem_rdata_i, hold_reg.use_second_mult ?
                              second_mult_i[`LBX_BIT_IDX_W-1:0] : mult_i[`LBX_BIT_IDX_W-1:0]);
      end else if (wb_hit && wb_we_i && wb_adr_i == A_STAT && wb_sel_i[0]) begin
        test_flag <= wb_dat_i[0];
      end
    end
  end
  // status word: pointer on top, mode bits, flag at bit 0
  assign status_word_one = {aux_select_ptr, 10'h0, product_shift_mode, test_flag};

  // aux registers and pointer
  // a branch update wins over a software write in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < AUX_COUNT; i++) begin
        aux_pointer_reg[i] <= 16'h0;
      end
      aux_select_ptr <= 3'h0;
      product_shift_mode <= 2'h0;
      dynamic_mask_reg <= 16'h0;
    end else if (ce_i) begin
      if (go && is_branch) begin
        // [RQ7] [RQ20] update applied taken or not
        if (instr_i.op == `LBX_OP_LOOP_AUX && instr_i.aux_mode == `LBX_AUX_NONE) begin
          // [RQ11] default decrement
          aux_pointer_reg[aux_select_ptr[AW-1:0]] <= cur_aux - 16'h1;
        end else if (instr_i.aux_mode == `LBX_AUX_INC) begin
          aux_pointer_reg[aux_select_ptr[AW-1:0]] <= cur_aux + 16'h1;
        end else if (instr_i.aux_mode == `LBX_AUX_DEC) begin
          aux_pointer_reg[aux_select_ptr[AW-1:0]] <= cur_aux - 16'h1;
        end
        if (instr_i.aux_ptr_load) begin
          aux_select_ptr <= instr_i.aux_ptr_next;
        end
      end else if (wb_hit && wb_we_i) begin
        case (wb_adr_i)
          A_MASK: dynamic_mask_reg <= wb_dat_i[15:0];
          A_STAT: product_shift_mode <= wb_dat_i[2:1];
          A_AUXP: aux_select_ptr <= wb_dat_i[2:0];
          A_AUX: aux_pointer_reg[aux_select_ptr[AW-1:0]] <= wb_dat_i[15:0];
          default: ;
        endcase
      end
    end
  end

  // branch issue with optional two-word delay
  // slot words are counted only while valid, so stalls are safe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      jump_o <= 1'b0;
      jump_addr_o <= `LBX_PC_RST;
      delay_cnt_reg <= 2'h0;
      pend_addr_reg <= `LBX_PC_RST;
    end else if (ce_i) begin
      jump_o <= 1'b0;
      if (delay_cnt_reg != 2'h0 && instr_valid_i) begin
        // [RQ8] count the two slot words
        delay_cnt_reg <= delay_cnt_reg - 2'h1;
        if (delay_cnt_reg == 2'h1) begin
          jump_o <= 1'b1;
          jump_addr_o <= pend_addr_reg;
        end
      end
      if (go && is_branch && cond_ok) begin
        // taken jump: target now or after the slot words
        // [RQ9] low accumulator half as target
        pend_addr_reg <= (instr_i.op == `LBX_OP_JUMP_ACC) ? acc_reg[15:0] : instr_i.imm;
        if (instr_i.delayed) begin
          // [RQ8] transfer after two words
          delay_cnt_reg <= `LBX_DELAY_WORDS;
        end else begin
          jump_o <= 1'b1;
          jump_addr_o <= (instr_i.op == `LBX_OP_JUMP_ACC) ? acc_reg[15:0] : instr_i.imm;
        end
      end
    end
  end

  // wishbone answer, one cycle
  // read data reflects the state before this edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else if (ce_i) begin
      wb_ack_o <= wb_hit;
      // unmapped offsets read as zero
      if (wb_hit) begin
        case (wb_adr_i)
          A_ACC: wb_dat_o <= acc_reg;
          A_MASK: wb_dat_o <= {16'h0, dynamic_mask_reg};
          A_STAT: wb_dat_o <= {16'h0, status_word_one};
          A_AUXP: wb_dat_o <= {29'h0, aux_select_ptr};
          A_AUX: wb_dat_o <= {16'h0, cur_aux};
          default: wb_dat_o <= 32'h0;
        endcase
      end
    end
  end

  // mirrored state outputs
  // mirrors lag the internal state by one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_o <= `LBX_ACC_RST;
      test_flag_o <= 1'b0;
      busy_o <= 1'b0;
    end else if (ce_i) begin
      acc_o <= acc_reg;
      test_flag_o <= test_flag;
      // busy over the read cycle and, for mask ops, the write
      busy_o <= go ? is_mem : (state_reg == LBX_MEM_RD && hold_reg.op == `LBX_OP_MASK_MEM);
    end
  end
  // the next sequential address is not needed by this slice
  logic unused_ok;
  assign unused_ok = ^next_pc_i;
endmodule : lbx_core
`default_nettype wire

/* rtl/lbx_params.svh */
// constants for the logic/branch/bit execution slice
// assumes inclusion by the package, the core module, the checker and the bench
`ifndef LBX_PARAMS_SVH
`define LBX_PARAMS_SVH
// opcode encodings carried on the decode port
`define LBX_OP_NOP 5'h00
`define LBX_OP_AND_MEM 5'h01
`define LBX_OP_AND_IMM 5'h02
`define LBX_OP_ADD_PROD 5'h03
`define LBX_OP_MASK_MEM 5'h04
`define LBX_OP_JUMP 5'h05
`define LBX_OP_JUMP_ACC 5'h06
`define LBX_OP_LOOP_AUX 5'h07
`define LBX_OP_JUMP_FSET 5'h08
`define LBX_OP_JUMP_FCLR 5'h09
`define LBX_OP_JUMP_CARRY 5'h0a
`define LBX_OP_COND_JUMP 5'h0b
`define LBX_OP_JUMP_NONNEG 5'h0c
`define LBX_OP_JUMP_POS 5'h0d
`define LBX_OP_JUMP_PIN_LOW 5'h0e
`define LBX_OP_BIT_TEST 5'h0f
`define LBX_OP_PROBE_IDX 5'h10
// cond_jump condition mask bit positions
`define LBX_CND_ZERO 0
`define LBX_CND_NONZERO 1
`define LBX_CND_NEG 2
`define LBX_CND_POS 3
`define LBX_CND_CARRY 4
`define LBX_CND_NOCARRY 5
`define LBX_CND_FSET 6
`define LBX_CND_FCLR 7
`define LBX_CND_PIN_LOW 8
// aux update modes
`define LBX_AUX_NONE 2'h0
`define LBX_AUX_INC 2'h1
`define LBX_AUX_DEC 2'h2
// widths and field limits
`define LBX_LOW_W 16
`define LBX_OLD_AUX_W 9
`define LBX_BIT_IDX_W 4
// delayed branch runs two words before the transfer
`define LBX_DELAY_WORDS 2'h2
// register word offsets on the wishbone port
`define LBX_REG_ACC 4'h0
`define LBX_REG_MASK 4'h1
`define LBX_REG_STAT 4'h2
`define LBX_REG_AUXP 4'h3
`define LBX_REG_AUX 4'h4
// product shift amounts per mode
`define LBX_PM_SHL1 1
`define LBX_PM_SHL4 4
`define LBX_PM_SHR6 6
// pin synchroniser idle value, pin high
`define LBX_PIN_IDLE 2'h3
// reset values
`define LBX_ACC_RST 32'h0000_0000
`define LBX_PC_RST 16'h0000
`endif

/* rtl/lbx_pkg.sv */
// types for the logic/branch/bit execution slice
// assumes lbx_params.svh is on the include path
`include "lbx_params.svh"
package lbx_pkg;
  // decoded instruction from fetch/decode
  typedef struct packed {
    logic [4:0] op;
    logic [15:0] imm;
    logic [3:0] shift;
    logic use_imm;
    logic delayed;
    logic [1:0] aux_mode;
    logic aux_ptr_load;
    logic [2:0] aux_ptr_next;
    logic [8:0] cond_mask;
    logic [3:0] bit_code;
    logic legacy_aux;
    logic use_second_mult;
  } lbx_instr_s;
  typedef enum logic [1:0] {
    LBX_IDLE = 2'b00,
    LBX_MEM_RD = 2'b01,
    LBX_MEM_WR = 2'b10
  } lbx_state_e;
endpackage : lbx_pkg

/* tb/lbx_core_props.sv */
// assertions on the execution slice ports
// assumes a bind into every lbx_core
`timescale 1ns/100ps
`default_nettype none
`include "lbx_params.svh"
module lbx_core_props
  import lbx_pkg::*;
(
  // clock and control
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic carry_i,
  // instruction side
  input wire logic instr_valid_i,
  input wire lbx_instr_s instr_i,
  input wire logic busy_o,
  input wire logic jump_o,
  input wire logic [15:0] jump_addr_o,
  // memory and state
  input wire logic dmem_rd_o,
  input wire logic dmem_wr_o,
  input wire logic [15:0] dmem_wdata_o,
  input wire logic [31:0] acc_o,
  input wire logic test_flag_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic take;
  logic [4:0] op;
  logic zero_reg;
  // opcode of an accepted undelayed instruction, else no-op
  assign take = instr_valid_i && ce_i && !busy_o;
  assign op = (take && !instr_i.delayed) ? instr_i.op : 5'h00;
  // remembers whether the word written back was zero
  always_ff @(posedge clk_i) if (dmem_wr_o) zero_reg <= dmem_wdata_o == 16'h0000;
  jump_target_a:
    assert property (op == `LBX_OP_JUMP |=> jump_o && jump_addr_o == $past(instr_i.imm))
      else $error("jump target wrong");
  delay_hold_a:
    assert property (take && instr_i.delayed && instr_i.op == `LBX_OP_JUMP |=> !jump_o)
      else $error("delayed jump too early");
  acc_target_a:
    assert property (op == `LBX_OP_JUMP_ACC |=> jump_o && jump_addr_o == acc_o[15:0])
      else $error("acc jump target wrong");
  flag_set_a:
    assert property (op == `LBX_OP_JUMP_FSET |=> jump_o == test_flag_o)
      else $error("flag set jump wrong");
  flag_clear_a:
    assert property (op == `LBX_OP_JUMP_FCLR |=> jump_o != test_flag_o)
      else $error("flag clear jump wrong");
  carry_jump_a:
    assert property (op == `LBX_OP_JUMP_CARRY |=> jump_o == $past(carry_i))
      else $error("carry jump wrong");
  nonneg_jump_a:
    assert property (op == `LBX_OP_JUMP_NONNEG |=> jump_o == !acc_o[31])
      else $error("nonneg jump wrong");
  pos_jump_a:
    assert property (op == `LBX_OP_JUMP_POS |=> jump_o == (!acc_o[31] && acc_o != 32'h0))
      else $error("positive jump wrong");
  write_back_a:
    assert property (dmem_wr_o |-> $past(dmem_rd_o))
      else $error("write without read");
  mask_flag_a:
    assert property (dmem_wr_o |-> ##[1:3] test_flag_o == zero_reg)
      else $error("mask flag wrong");
endmodule : lbx_core_props
bind lbx_core lbx_core_props u_props (.clk_i, .rst_i, .ce_i, .carry_i, .instr_valid_i,
  .instr_i, .busy_o, .jump_o, .jump_addr_o, .dmem_rd_o, .dmem_wr_o, .dmem_wdata_o,
  .acc_o, .test_flag_o);
`default_nettype wire

/* tb/lbx_dmem_model.sv */
// one-word data memory behind the slice
// assumes read data must stand while the read strobe stands
`timescale 1ns/100ps
`default_nettype none
module lbx_dmem_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // core side
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic [15:0] wdata_i,
  output logic [15:0] rdata_o,
  // bench preload
  input wire logic load_i,
  input wire logic [15:0] load_data_i
);
  logic [15:0] mem_reg;
  always_ff @(posedge clk_i) begin
    mem_reg <= rst_i ? 16'h0000 : (load_i ? load_data_i : (wr_i ? wdata_i : mem_reg));
  end
  // answer a read in the strobe's own cycle, else show the inverse
  assign rdata_o = rd_i ? mem_reg : ~mem_reg;
endmodule : lbx_dmem_model
`default_nettype wire

/* tb/lbx_core_tb.sv */
// self-checking bench for the execution slice
// assumes the one-word memory model and the checker bind
`timescale 1ns/100ps
`default_nettype none
`include "lbx_params.svh"
module lbx_core_tb
  import lbx_pkg::*;
;
  logic clk_i = 0, rst_i = 1, ce_i = 1, instr_valid_i = 0, carry_i = 0;
  logic external_branch_input_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [3:0] wb_adr_i = 0, wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 0, product_i = 0, wb_dat_o, acc_o, a, x, q;
  logic [15:0] next_pc_i = 0, mult_i = 0, second_mult_i = 0, m, k;
  logic [15:0] jump_addr_o, dmem_wdata_o, dmem_rdata_i, ld_d = 0;
  logic busy_o, jump_o, dmem_rd_o, dmem_wr_o, wb_ack_o, test_flag_o, ld = 0;
  logic [3:0] b;
  logic [63:0] e;
  logic [31:0] av[4] = '{32'h0, 32'h1, 32'h8000_0000, 32'h7fff_0000};
  lbx_instr_s instr_i = '0, ins;
  logic [63:0] rd_q[$];
  logic [15:0] jp_q[$], wr_q[$];
  int seed = 54, failures = 0, n_checks = 0;
  lbx_core dut (.*);
  lbx_dmem_model u_mem (.clk_i, .rst_i, .rd_i(dmem_rd_o), .wr_i(dmem_wr_o),
    .wdata_i(dmem_wdata_o), .rdata_o(dmem_rdata_i), .load_i(ld), .load_data_i(ld_d));
  // clock at 20 MHz
  always #25 clk_i = ~clk_i;
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic stop_test;
    cmp(rd_q.size() + jp_q.size() + wr_q.size(), 0);
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test
  task automatic wb(input logic w, input logic [3:0] ad, input logic [31:0] d);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= w;
    wb_adr_i <= ad;
    wb_dat_i <= d;
    @(posedge clk_i);
    while (!wb_ack_o) @(posedge clk_i);
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    @(posedge clk_i);
  endtask : wb
  task automatic rd(input logic [3:0] ad, input logic [31:0] ex, input logic [31:0] mk);
    rd_q.push_back({mk, ex & mk});
    wb(0, ad, 0);
  endtask : rd
  task automatic load(input logic [15:0] v);
    ld <= 1;
    ld_d <= v;
    @(posedge clk_i);
    ld <= 0;
  endtask : load
  task automatic ex(input logic [4:0] o, input logic [15:0] imm);
    ins.op = o;
    ins.imm = imm;
    instr_i <= ins;
    instr_valid_i <= 1;
    @(posedge clk_i);
    instr_valid_i <= 0;
    repeat (4) @(posedge clk_i);
  endtask : ex
  task automatic br(input logic [4:0] o, input logic tk);
    k = 16'($random(seed));
    if (tk) jp_q.push_back(k);
    ex(o, k);
  endtask : br
  // results compared against the oldest note
  always @(posedge clk_i) begin
    if (wb_ack_o && !wb_we_i) begin
      e = rd_q.pop_front();
      cmp(wb_dat_o & e[63:32], e[31:0]);
    end
    if (jump_o) cmp(jump_addr_o, jp_q.size() ? jp_q.pop_front() : 32'hxxxx_xxxx);
    if (dmem_wr_o) cmp(dmem_wdata_o, wr_q.size() ? wr_q.pop_front() : 32'hxxxx_xxxx);
  end
  // watchdog
  initial begin
    #(50 * 20000);
    failures++;
    stop_test();
  end
  // main sequence
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 0;
    rd(0, 0, '1);
    rd(2, 0, '1);
    wb(1, 4'hf, 32'hffff_ffff);
    rd(4'hf, 0, '1);
    for (int i = 0; i < 4; i++) begin
      a = $random(seed);
      m = 16'($random(seed));
      p_and: begin
        wb(1, 0, a);
        load(m);
        ins = '0;
        ex(`LBX_OP_AND_MEM, 0);
        rd(0, {16'h0, m & a[15:0]}, '1);
        wb(1, 0, a);
        ins.shift = 4'(i * 5);
        ex(`LBX_OP_AND_IMM, m);
        rd(0, a & ({16'h0, m} << (i * 5)), '1);
        product_i <= $random(seed);
        wb(1, 2, {29'h0, 2'(i), 1'b0});
        wb(1, 0, a);
        ex(`LBX_OP_ADD_PROD, 0);
        q = i == 3 ? 32'($signed(product_i) >>> 6) : product_i << (i == 1 ? 1 : i * 2);
        rd(0, a + q, '1);
      end
    end
    for (int i = 0; i < 3; i++) begin
      m = 16'($random(seed));
      k = i == 0 ? ~m : 16'($random(seed));
      load(m);
      wb(1, 1, {16'h0, k});
      ins = '0;
      ins.use_imm = i != 2;
      wr_q.push_back(m & k);
      ex(`LBX_OP_MASK_MEM, ins.use_imm ? k : ~k);
      rd(2, 32'((m & k) == 0), 1);
    end
    for (int i = 0; i < 4; i++) begin
      m = 16'($random(seed));
      b = 4'($random(seed));
      load(m);
      ins = '0;
      ins.bit_code = b;
      ex(`LBX_OP_BIT_TEST, 0);
      rd(2, 32'(m[15 - b]), 1);
      mult_i <= {12'h0, i[0] ? ~b : b};
      second_mult_i <= {12'hfff, i[0] ? b : ~b};
      ins.use_second_mult = i[0];
      ex(`LBX_OP_PROBE_IDX, 0);
      rd(2, 32'(m[15 - b]), 1);
    end
    for (int i = 0; i < 4; i++) begin
      wb(1, 2, 32'(i[0]));
      carry_i <= i[1];
      ins = '0;
      br(`LBX_OP_JUMP_FSET, i[0]);
      br(`LBX_OP_JUMP_FCLR, !i[0]);
      br(`LBX_OP_JUMP_CARRY, i[1]);
      ins.cond_mask = 9'h050;
      br(`LBX_OP_COND_JUMP, i == 3);
      ins.cond_mask = 9'h0a0;
      br(`LBX_OP_COND_JUMP, i == 0);
      external_branch_input_i <= i[0];
      repeat (3) @(posedge clk_i);
      br(`LBX_OP_JUMP_PIN_LOW, !i[0]);
      ins.cond_mask = 9'h100;
      br(`LBX_OP_COND_JUMP, !i[0]);
      wb(1, 0, av[i]);
      ins.cond_mask = 9'h001;
      br(`LBX_OP_COND_JUMP, av[i] == 0);
      br(`LBX_OP_JUMP_NONNEG, !av[i][31]);
      br(`LBX_OP_JUMP_POS, !av[i][31] && av[i] != 0);
      ins.cond_mask = 9'h006;
      br(`LBX_OP_COND_JUMP, av[i][31]);
      ins.cond_mask = 9'h00a;
      br(`LBX_OP_COND_JUMP, !av[i][31] && av[i] != 0);
      jp_q.push_back(av[i][15:0]);
      ex(`LBX_OP_JUMP_ACC, ~av[i][15:0]);
      ins = '0;
      ins.legacy_aux = i == 2;
      ins.aux_mode = i == 0 ? `LBX_AUX_NONE : (i == 1 ? `LBX_AUX_DEC : `LBX_AUX_INC);
      x = i == 0 ? 5 : (i == 1 ? 0 : 32'h200);
      wb(1, 4, x);
      br(`LBX_OP_LOOP_AUX, i == 0 || i == 3);
      rd(4, i < 2 ? x - 1 : x + 1, 32'hffff);
    end
    ins = '0;
    ins.aux_ptr_load = 1;
    ins.aux_ptr_next = 3'h5;
    br(`LBX_OP_JUMP, 1);
    rd(2, 32'ha000, 32'he000);
    // enable low: the offered instruction must not be taken
    ce_i <= 0;
    ins = '0;
    ex(`LBX_OP_AND_IMM, 16'h0);
    ce_i <= 1;
    rd(0, av[3], '1);
    ins = '0;
    ins.delayed = 1;
    br(`LBX_OP_JUMP, 1);
    ins = '0;
    ex(`LBX_OP_NOP, 0);
    ex(`LBX_OP_NOP, 0);
    stop_test();
  end
endmodule : lbx_core_tb
`default_nettype wire
